// [inc/ucafr_pkg.sv]
// Package for the USB control, address and frame-number register group.
// Assumes a 32-bit APB register bus and a single 50 MHz system clock.
package ucafr_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] UCAFR_CONTROL_OFS = 8'h00;
  localparam logic [7:0] UCAFR_ADDRESS_OFS = 8'h04;
  localparam logic [7:0] UCAFR_FRAME_LOW_OFS = 8'h08;
  localparam logic [7:0] UCAFR_FRAME_HIGH_OFS = 8'h0c;

  // ****************************************
  // Control and address register fields
  // ****************************************
  localparam int UCAFR_BIT_J = 7;
  localparam int UCAFR_BIT_SE0 = 6;
  localparam int UCAFR_BIT_PKT = 5;
  localparam int UCAFR_BIT_BUSRST = 4;
  localparam int UCAFR_BIT_HOST_CAPABILITY_ENABLE = 3;
  localparam int UCAFR_BIT_RESUME = 2;
  localparam int UCAFR_BIT_PPRST = 1;
  localparam int UCAFR_BIT_EN = 0;
  localparam int UCAFR_BIT_SLOW = 7;
  localparam logic [7:0] UCAFR_CONTROL_RESET = 8'h00;
  localparam logic [7:0] UCAFR_ADDRESS_RESET = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int UCAFR_CLK_HZ = 50000000;
  localparam int UCAFR_SOF_PERIOD_US = 1000;
  localparam int UCAFR_SOF_CYCLES = UCAFR_CLK_HZ / 1000000 * UCAFR_SOF_PERIOD_US;
  localparam int UCAFR_LS_EOP_NS = 1333;
  localparam int UCAFR_LS_EOP_CYCLES = (UCAFR_LS_EOP_NS * 50 + 999) / 1000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic bus_reset_drive;
    logic resume_drive;
    logic ls_eop_drive;
    logic frame_start_pulse;
  } ucafr_line_ctl_t;

  typedef struct packed {
    logic valid;
    logic [10:0] number;
  } ucafr_sof_rx_t;

  typedef enum logic [2:0] {
    UCAFR_RES_IDLE = 3'b001,
    UCAFR_RES_DRIVE = 3'b010,
    UCAFR_RES_EOP = 3'b100
  } ucafr_res_state_t;

endpackage : ucafr_pkg

// [rtl/ucafr_regs.sv]
// USB control, address and frame-number register group with APB slave.
// Assumes core events (SETUP, SOF, token busy) are pulses or levels on CLK,
// while the raw J and SE0 levels come straight from the transceiver and
// pass a two-flop synchroniser here.
// Assumes one APB master; the slave never inserts wait states.
// Host-mode logic outside this block listens to HOST_LOGIC_RESET.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module ucafr_regs
  import ucafr_pkg::*;
#(
  parameter int SOF_CYCLES = UCAFR_SOF_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Raw line state from transceiver
  input wire logic LINE_J,
  input wire logic LINE_SE0,
  // Core events
  input wire logic SETUP_RX,
  input wire ucafr_sof_rx_t SOF_RX,
  input wire logic TOKEN_ACTIVE,
  // Controls to core and bus
  output ucafr_line_ctl_t LINE_CTL,
  output logic HOST_LOGIC_RESET,
  output logic MODULE_ENABLE,
  output logic PACKET_HOLD,
  output logic PINGPONG_EVEN_FORCE,
  output logic SLOW_TOKEN,
  output logic [6:0] DEVICE_ADDRESS
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    addr_is = (a[7:2] == ofs[7:2]);
  endfunction : addr_is

  logic [1:0] j_sync_r;
  logic [1:0] se0_sync_r;
  logic pkt_dis_r;
  logic bus_rst_r;
  logic host_en_r;
  logic resume_r;
  logic pp_rst_r;
  logic en_r;
  logic slow_r;
  logic [6:0] dev_addr_r;
  logic [10:0] frame_r;
  logic host_rst_r;
  logic [31:0] sof_cnt_r;
  logic sof_pulse_r;
  ucafr_res_state_t res_state_r;
  ucafr_res_state_t res_state_nxt;
  logic [7:0] eop_cnt_r;
  logic [31:0] rdata_nxt;

  wire logic wr_en = PSEL && PENABLE && PWRITE;
  wire logic wr_ctl = wr_en && addr_is(PADDR, UCAFR_CONTROL_OFS);
  wire logic wr_adr = wr_en && addr_is(PADDR, UCAFR_ADDRESS_OFS);
  wire logic mapped = addr_is(PADDR, UCAFR_CONTROL_OFS) || addr_is(PADDR, UCAFR_ADDRESS_OFS)
    || addr_is(PADDR, UCAFR_FRAME_LOW_OFS) || addr_is(PADDR, UCAFR_FRAME_HIGH_OFS);
  // SOF timer is held at zero while not a running host, and restarts on a host toggle
  wire logic sof_stop = !(host_en_r && en_r) || host_rst_r;
  wire logic sof_wrap = (sof_cnt_r == 32'(SOF_CYCLES - 1));

  // ****************************************
  // Line state synchronisers
  // ****************************************
  // Only the second flop of each pair feeds the read path
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      j_sync_r <= 2'h0;
    end else begin
      j_sync_r <= {j_sync_r[0], LINE_J};
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      se0_sync_r <= 2'h0;
    end else begin
      se0_sync_r <= {se0_sync_r[0], LINE_SE0};
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  // Bits 7 and 6 are live flags read from the synchronisers, with no register of their own
  // bus reset bit
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_rst_r <= UCAFR_CONTROL_RESET[UCAFR_BIT_BUSRST];
    end else if (wr_ctl) begin
      bus_rst_r <= PWDATA[UCAFR_BIT_BUSRST];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      host_en_r <= UCAFR_CONTROL_RESET[UCAFR_BIT_HOST_CAPABILITY_ENABLE];
    end else if (wr_ctl) begin
      host_en_r <= PWDATA[UCAFR_BIT_HOST_CAPABILITY_ENABLE];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      resume_r <= UCAFR_CONTROL_RESET[UCAFR_BIT_RESUME];
    end else if (wr_ctl) begin
      resume_r <= PWDATA[UCAFR_BIT_RESUME];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pp_rst_r <= UCAFR_CONTROL_RESET[UCAFR_BIT_PPRST];
    end else if (wr_ctl) begin
      pp_rst_r <= PWDATA[UCAFR_BIT_PPRST];
    end
  end

  // Module enable in device mode, SOF enable in host mode
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      en_r <= UCAFR_CONTROL_RESET[UCAFR_BIT_EN];
    end else if (wr_ctl) begin
      en_r <= PWDATA[UCAFR_BIT_EN];
    end
  end

  // Packet disable: hardware set beats software clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pkt_dis_r <= UCAFR_CONTROL_RESET[UCAFR_BIT_PKT];
    end else if (SETUP_RX && !host_en_r) begin
      pkt_dis_r <= 1'b1;
    end else if (wr_ctl && !host_en_r) begin
      pkt_dis_r <= PWDATA[UCAFR_BIT_PKT];
    end
  end

  // toggle resets host
  // Any write that flips bit 3 gives one pulse, whichever way it flips;
  // writes that leave bit 3 alone never disturb running host logic.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      host_rst_r <= 1'b0;
    end else begin
      host_rst_r <= wr_ctl && (PWDATA[UCAFR_BIT_HOST_CAPABILITY_ENABLE] != host_en_r);
    end
  end

  // ****************************************
  // Address register
  // ****************************************
  // low-speed select
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      slow_r <= UCAFR_ADDRESS_RESET[UCAFR_BIT_SLOW];
    end else if (wr_adr) begin
      slow_r <= PWDATA[UCAFR_BIT_SLOW];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dev_addr_r <= UCAFR_ADDRESS_RESET[6:0];
    end else if (wr_adr) begin
      dev_addr_r <= PWDATA[6:0];
    end
  end

  // ****************************************
  // Frame number capture
  // ****************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      frame_r <= 11'h000;
    end else if (SOF_RX.valid) begin
      frame_r <= SOF_RX.number;
    end
  end

  // ****************************************
  // SOF generation
  // ****************************************
  // one SOF per 1 ms
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sof_cnt_r <= 32'h0;
    end else if (sof_stop || sof_wrap) begin
      sof_cnt_r <= 32'h0;
    end else begin
      sof_cnt_r <= sof_cnt_r + 32'h1;
    end
  end

  // First pulse comes one full period after the enable, never at once
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sof_pulse_r <= 1'b0;
    end else begin
      sof_pulse_r <= !sof_stop && sof_wrap;
    end
  end

  // ****************************************
  // Resume sequencer
  // ****************************************
  // Resume drive starts one cycle after the bit is set. When the bit is
  // cleared in host mode a low-speed EOP of fixed length follows; in
  // device mode the lines are simply released.
  always_comb begin
    res_state_nxt = res_state_r;
    case (res_state_r)
      UCAFR_RES_IDLE: begin
        if (resume_r) begin
          res_state_nxt = UCAFR_RES_DRIVE;
        end
      end
      UCAFR_RES_DRIVE: begin
        if (!resume_r) begin
          res_state_nxt = host_en_r ? UCAFR_RES_EOP : UCAFR_RES_IDLE;
        end
      end
      UCAFR_RES_EOP: begin
        if (eop_cnt_r == 8'(UCAFR_LS_EOP_CYCLES - 1)) begin
          res_state_nxt = UCAFR_RES_IDLE;
        end
      end
      default: begin
        res_state_nxt = UCAFR_RES_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      res_state_r <= UCAFR_RES_IDLE;
    end else begin
      res_state_r <= res_state_nxt;
    end
  end

  // EOP length counter, only runs in the EOP state
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      eop_cnt_r <= 8'h00;
    end else if (res_state_r == UCAFR_RES_EOP) begin
      eop_cnt_r <= eop_cnt_r + 8'h01;
    end else begin
      eop_cnt_r <= 8'h00;
    end
  end

  // ****************************************
  // APB read path
  // ****************************************
  always_comb begin
    rdata_nxt = 32'h0;
    if (addr_is(PADDR, UCAFR_CONTROL_OFS)) begin
      rdata_nxt[UCAFR_BIT_J] = j_sync_r[1];
      rdata_nxt[UCAFR_BIT_SE0] = se0_sync_r[1];
      rdata_nxt[UCAFR_BIT_PKT] = host_en_r ? TOKEN_ACTIVE : pkt_dis_r;
      rdata_nxt[UCAFR_BIT_BUSRST] = bus_rst_r;
      rdata_nxt[UCAFR_BIT_HOST_CAPABILITY_ENABLE] = host_en_r;
      rdata_nxt[UCAFR_BIT_RESUME] = resume_r;
      rdata_nxt[UCAFR_BIT_PPRST] = pp_rst_r;
      rdata_nxt[UCAFR_BIT_EN] = en_r;
    end else if (addr_is(PADDR, UCAFR_ADDRESS_OFS)) begin
      rdata_nxt[7:0] = {slow_r, dev_addr_r};
    end else if (addr_is(PADDR, UCAFR_FRAME_LOW_OFS)) begin
      rdata_nxt[7:0] = frame_r[7:0];
    end else if (addr_is(PADDR, UCAFR_FRAME_HIGH_OFS)) begin
      rdata_nxt[2:0] = frame_r[10:8];
    end
  end

  // Read data is captured in the setup cycle, so it is settled well before
  // the access edge at which the master takes it, and holds until the
  // next read setup.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= rdata_nxt;
    end
  end

  // read-only bits not stored
  // Zero wait states; unmapped offsets answer with an error and no effect
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // ****************************************
  // Outputs
  // ****************************************
  // reset drive in host only
  assign LINE_CTL.bus_reset_drive = bus_rst_r && host_en_r;
  assign LINE_CTL.resume_drive = (res_state_r == UCAFR_RES_DRIVE);
  assign LINE_CTL.ls_eop_drive = (res_state_r == UCAFR_RES_EOP);
  assign LINE_CTL.frame_start_pulse = sof_pulse_r;
  assign HOST_LOGIC_RESET = host_rst_r;
  // device-mode module enable
  // Bit 0 means SOF enable in host mode, so it must not enable the device
  assign MODULE_ENABLE = en_r && !host_en_r;
  assign PACKET_HOLD = pkt_dis_r && !host_en_r;
  assign PINGPONG_EVEN_FORCE = pp_rst_r;
  assign SLOW_TOKEN = slow_r;
  assign DEVICE_ADDRESS = dev_addr_r;

endmodule : ucafr_regs

// [verification/ucafr_regs_asserts.sv]
// Checker for the control, address and frame register group.
// Assumes it is bound to ucafr_regs and sees only its ports.
`timescale 1ns/1ps
module ucafr_asserts
  import ucafr_pkg::*;
#(
  parameter int SOF_CYCLES = UCAFR_SOF_CYCLES
) (
  // Clock, reset and APB
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PSLVERR,
  // Core side
  input wire logic SETUP_RX,
  input wire ucafr_line_ctl_t LINE_CTL,
  input wire logic HOST_LOGIC_RESET,
  input wire logic MODULE_ENABLE,
  input wire logic PACKET_HOLD,
  input wire logic PINGPONG_EVEN_FORCE,
  input wire logic SLOW_TOKEN,
  input wire logic [6:0] DEVICE_ADDRESS
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic wr, wc, host_r;
  assign wr = PSEL && PENABLE && PWRITE;
  assign wc = wr && PADDR[7:2] == UCAFR_CONTROL_OFS[7:2];
  // Shadow of the host enable bit
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) host_r <= 1'b0;
    else if (wc) host_r <= PWDATA[3];
  end
  chk_unmapped_err: assert property (PSEL && PENABLE && PADDR >= 8'h10 |-> PSLVERR)
    else $error("no error on unmapped access");
  chk_addr_write: assert property (
    wr && PADDR == UCAFR_ADDRESS_OFS |=> {SLOW_TOKEN, DEVICE_ADDRESS} == $past(PWDATA[7:0]))
    else $error("address register not written");
  chk_even_force: assert property (wc |=> PINGPONG_EVEN_FORCE == $past(PWDATA[1]))
    else $error("even force does not follow bit 1");
  chk_host_toggle: assert property (wc && PWDATA[3] != host_r |-> ##[1:2] HOST_LOGIC_RESET)
    else $error("no host logic reset on toggle");
  chk_reset_pulse: assert property (HOST_LOGIC_RESET |=> !HOST_LOGIC_RESET)
    else $error("host logic reset longer than one cycle");
  chk_dev_enable: assert property (MODULE_ENABLE |-> !host_r)
    else $error("module enable in host mode");
  chk_setup_hold: assert property (SETUP_RX && !host_r && !wc |=> PACKET_HOLD)
    else $error("setup did not hold packets");
  chk_bus_reset: assert property (LINE_CTL.bus_reset_drive |-> host_r)
    else $error("bus reset outside host mode");
  chk_sof_gap: assert property (
    LINE_CTL.frame_start_pulse |=> (!LINE_CTL.frame_start_pulse) [*8])
    else $error("frame start pulses too close");
  cov_host_reset: cover property (HOST_LOGIC_RESET);
  cov_sof: cover property (LINE_CTL.frame_start_pulse);
  cov_eop: cover property (LINE_CTL.ls_eop_drive);
endmodule : ucafr_asserts

bind ucafr_regs ucafr_asserts #(.SOF_CYCLES(SOF_CYCLES)) chk_u (.CLK(CLK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PSLVERR(PSLVERR), .SETUP_RX(SETUP_RX), .LINE_CTL(LINE_CTL),
  .HOST_LOGIC_RESET(HOST_LOGIC_RESET), .MODULE_ENABLE(MODULE_ENABLE),
  .PACKET_HOLD(PACKET_HOLD), .PINGPONG_EVEN_FORCE(PINGPONG_EVEN_FORCE),
  .SLOW_TOKEN(SLOW_TOKEN), .DEVICE_ADDRESS(DEVICE_ADDRESS));

// [verification/ucafr_far.sv]
// Far-side model: line levels and token events from the bus.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
module ucafr_far
  import ucafr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Bus events
  output logic line_j,
  output logic line_se0,
  output logic setup_rx,
  output ucafr_sof_rx_t sof_rx,
  output logic token_active
);
  initial begin
    line_j = 1'b0;
    line_se0 = 1'b0;
    setup_rx = 1'b0;
    sof_rx = '0;
    token_active = 1'b0;
  end
  // Number is scrambled outside the valid cycle
  task automatic send_sof(input logic [10:0] n);
    sof_rx <= '{1'b1, n};
    @(posedge clk);
    sof_rx <= '{1'b0, ~n};
  endtask : send_sof
  task automatic send_setup;
    setup_rx <= 1'b1;
    @(posedge clk);
    setup_rx <= 1'b0;
  endtask : send_setup
  task automatic lines(input logic j, input logic s);
    line_j <= j;
    line_se0 <= s;
  endtask : lines
endmodule : ucafr_far

// [verification/tb_usb_control_address_frame_regs.sv]
// Testbench for the control, address and frame register group.
// Assumes the far-side model ucafr_far and a 50 MHz clock.
`timescale 1ns/1ps
module tb_usb_control_address_frame_regs
  import ucafr_pkg::*;
;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, lj, lse0, setup, busy, hrst, men, hold, ppf, slow;
  logic [6:0] dadr;
  ucafr_sof_rx_t sof;
  ucafr_line_ctl_t lc;
  int n_fail = 0, compares = 0;
  always #10 clk = ~clk;
  ucafr_regs #(.SOF_CYCLES(20)) dut_u (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LINE_J(lj), .LINE_SE0(lse0), .SETUP_RX(setup),
    .SOF_RX(sof), .TOKEN_ACTIVE(busy), .LINE_CTL(lc), .HOST_LOGIC_RESET(hrst),
    .MODULE_ENABLE(men), .PACKET_HOLD(hold), .PINGPONG_EVEN_FORCE(ppf),
    .SLOW_TOKEN(slow), .DEVICE_ADDRESS(dadr));
  ucafr_far far_u (.clk(clk), .line_j(lj), .line_se0(lse0), .setup_rx(setup),
    .sof_rx(sof), .token_active(busy));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int i = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 40);
    if (i >= 40) n_fail++;
    if (i >= 40) end_sim();
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  task automatic cnt_sof(input int e);
    int c = 0;
    repeat (40) begin
      @(posedge clk);
      c += lc.frame_start_pulse;
    end
    chk(c, e);
  endtask : cnt_sof
  task automatic t_regs;
    rd(UCAFR_CONTROL_OFS, 32'h0);
    rd(8'h10, 32'h0);
    chk(err, 1'b1);
    wr(UCAFR_ADDRESS_OFS, 32'hffff_ff25);
    rd(UCAFR_ADDRESS_OFS, 32'h25);
    wr(UCAFR_ADDRESS_OFS, 32'h0000_00da);
    chk(slow, 1'b1);
    wr(UCAFR_FRAME_LOW_OFS, 32'hffff_ffff);
    wr(UCAFR_CONTROL_OFS, 32'h0000_00c0);
    rd(UCAFR_FRAME_LOW_OFS, 32'h0);
    rd(UCAFR_CONTROL_OFS, 32'h0);
    for (int k = 0; k < 2; k++) begin
      far_u.send_sof(k ? 11'h7ff : 11'h5a3);
      rd(UCAFR_FRAME_LOW_OFS, k ? 32'hff : 32'ha3);
      rd(UCAFR_FRAME_HIGH_OFS, k ? 32'h7 : 32'h5);
    end
    $display("test registers done");
  endtask : t_regs
  task automatic t_dev;
    far_u.lines(1, 0);
    repeat (4) @(posedge clk);
    rd(UCAFR_CONTROL_OFS, 32'h80);
    far_u.lines(0, 1);
    repeat (4) @(posedge clk);
    rd(UCAFR_CONTROL_OFS, 32'h40);
    far_u.lines(0, 0);
    repeat (4) @(posedge clk);
    far_u.send_setup();
    rd(UCAFR_CONTROL_OFS, 32'h20);
    wr(UCAFR_CONTROL_OFS, 32'h03);
    chk({hold, men, ppf}, 3'b011);
    $display("test device done");
  endtask : t_dev
  task automatic t_host;
    int i = 0;
    wr(UCAFR_CONTROL_OFS, 32'h19);
    chk({men, lc.bus_reset_drive}, 2'b01);
    far_u.token_active <= 1;
    rd(UCAFR_CONTROL_OFS, 32'h39);
    far_u.token_active <= 0;
    rd(UCAFR_CONTROL_OFS, 32'h19);
    wr(UCAFR_CONTROL_OFS, 32'h0d);
    @(posedge clk);
    chk({lc.bus_reset_drive, lc.resume_drive}, 2'b01);
    // resume hold, scaled down for simulation
    repeat (20) @(posedge clk);
    cnt_sof(2);
    wr(UCAFR_CONTROL_OFS, 32'h08);
    @(posedge clk);
    while (lc.ls_eop_drive === 1'b1 && i < 200) begin
      @(posedge clk);
      i++;
    end
    chk(i, UCAFR_LS_EOP_CYCLES);
    cnt_sof(0);
    $display("test host done");
  endtask : t_host
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    t_regs();
    t_dev();
    t_host();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end
endmodule : tb_usb_control_address_frame_regs
